// File: parallel_config_byte_port_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module parallel_config_byte_port_tb;
   import pcbp_pkg::*;

   logic              clk_sys;
   logic              resetn;
   logic              keep_port;
   logic              cmd_valid;
   logic              cmd_read;
   logic [BUS_W-1:0]  cmd_byte;
   logic              cmd_ack;
   logic [BUS_W-1:0]  rd_byte;
   logic              rd_valid;
   logic              busy;
   logic [BUS_W-1:0]  cfg_byte;
   logic              cfg_byte_valid;
   logic              configured;
   logic              aborted;
   logic              port_in_user_mode;
   logic [31:0]       rnd;
   int                errors;
   int                n_checks;
   logic [BUS_W-1:0]  img [CFG_LEN];
   logic [BUS_W-1:0]  wq [$];
   logic [BUS_W-1:0]  rq [$];
   logic [BUS_W-1:0]  bq [$];
   logic [BUS_W-1:0]  we;
   logic [BUS_W-1:0]  re;
   logic [BUS_W-1:0]  be;

   pcbp_if pcbp_if_i ();

   pcbp_device pcbp_device_i (.link(pcbp_if_i), .clk_sys(clk_sys), .resetn(resetn), .keep_port(keep_port),
      .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid), .configured(configured), .aborted(aborted),
      .port_in_user_mode(port_in_user_mode));

   pcbp_master pcbp_master_i (.link(pcbp_if_i), .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_read(cmd_read), .cmd_byte(cmd_byte), .cmd_ack(cmd_ack), .rd_byte(rd_byte), .rd_valid(rd_valid),
      .busy(busy));

   pcbp_checker pcbp_checker_i (.clk_sys(clk_sys), .resetn(resetn), .config_clock(pcbp_if_i.config_clock),
      .select_n(pcbp_if_i.select_n), .read_write_n(pcbp_if_i.read_write_n), .mst_data(pcbp_if_i.mst_data),
      .mst_data_oe_n(pcbp_if_i.mst_data_oe_n), .dev_data(pcbp_if_i.dev_data),
      .dev_data_oe_n(pcbp_if_i.dev_data_oe_n));

   initial clk_sys = 1'b0;
   always #12.5 clk_sys = ~clk_sys;

   // ********************
   // Helpers
   // ********************
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // Byte bit 7 rides on bus line 0
   function automatic logic [BUS_W-1:0] line_order(input logic [BUS_W-1:0] b);
      logic [BUS_W-1:0] r;
      for (int i = 0; i < BUS_W; i++) begin
         r[i] = b[BUS_W-1-i];
      end
      return r;
   endfunction : line_order

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : settle

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   task automatic done_test(input string s);
      $display("test %s done", s);
   endtask : done_test

   // Command held until one edge after the edge where the acknowledge is seen
   task automatic cmd(input logic rd, input logic [BUS_W-1:0] b);
      int n;
      n = 0;
      @(posedge clk_sys);
      #2;
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_byte = b;
      while (cmd_ack !== 1'b1 && n < 40) begin
         settle(1);
         n++;
      end
      if (n >= 40) begin
         errors++;
         $display("wrong value cmd_ack expected 1 seen %b", cmd_ack);
      end
      settle(1);
      cmd_valid = 1'b0;
      cmd_read = rnd[8];
      cmd_byte = rnd[15:8];
   endtask : cmd

   task automatic put(input int cnt, input bit store);
      for (int i = 0; i < cnt; i++) begin
         rnd = lfsr_next(rnd);
         if (store) begin
            img[i % CFG_LEN] = rnd[7:0];
            wq.push_back(rnd[7:0]);
         end
         bq.push_back(line_order(rnd[7:0]));
         cmd(1'b0, rnd[7:0]);
      end
   endtask : put

   task automatic get(input logic [BUS_W-1:0] exp);
      rq.push_back(exp);
      rnd = lfsr_next(rnd);
      cmd(1'b1, rnd[7:0]);
   endtask : get

   // ********************
   // Result watchers
   // ********************
   always @(posedge clk_sys) begin
      if (cfg_byte_valid === 1'b1) begin
         if (wq.size() == 0) begin
            `CHK("cfg_byte_valid", 1'b0, cfg_byte_valid)
         end else begin
            we = wq.pop_front();
            `CHK("cfg_byte", we, cfg_byte)
         end
      end
      if (rd_valid === 1'b1) begin
         if (rq.size() == 0) begin
            `CHK("rd_valid", 1'b0, rd_valid)
         end else begin
            re = rq.pop_front();
            `CHK("rd_byte", re, rd_byte)
         end
      end
   end

   always @(posedge pcbp_if_i.config_clock) begin
      if (pcbp_if_i.select_n === 1'b0 && pcbp_if_i.read_write_n === 1'b0) begin
         be = bq.pop_front();
         `CHK("config_byte_bus", be, pcbp_if_i.config_byte_bus)
      end
   end

   initial begin
      #1000000;
      errors++;
      $display("watchdog expired");
      conclude();
   end

   // ********************
   // Tests
   // ********************
   initial begin
      errors = 0;
      n_checks = 0;
      rnd = 32'h5ae48637;
      resetn = 1'b0;
      keep_port = 1'b1;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_byte = 8'h00;
      repeat (6) @(posedge clk_sys);
      #2;
      resetn = 1'b1;
      settle(60);
      `CHK("configured", 1'b0, configured)
      `CHK("busy", 1'b0, busy)
      done_test("reset");
      get(BUS_PULL);
      settle(30);
      `CHK("aborted", 1'b0, aborted)
      done_test("early read");
      put(CFG_LEN, 1'b1);
      settle(40);
      `CHK("configured", 1'b1, configured)
      `CHK("port_in_user_mode", 1'b0, port_in_user_mode)
      get(img[0]);
      get(img[0]);
      settle(30);
      done_test("load and readback");
      keep_port = 1'b0;
      settle(60);
      `CHK("port_in_user_mode", 1'b1, port_in_user_mode)
      get(BUS_PULL);
      put(2, 1'b0);
      settle(30);
      done_test("user mode");
      keep_port = 1'b1;
      settle(60);
      put(3, 1'b1);
      get(BUS_PULL);
      settle(30);
      `CHK("aborted", 1'b1, aborted)
      put(CFG_LEN, 1'b1);
      settle(40);
      `CHK("configured", 1'b1, configured)
      done_test("abort and reload");
      conclude();
   end

endmodule : parallel_config_byte_port_tb

// File: pcbp_checker.sv
`timescale 1ns/1ps
// ********************
// Link protocol checker
// ********************
module pcbp_checker (
   input wire logic                        clk_sys,
   input wire logic                        resetn,
   input wire logic                        config_clock,
   input wire logic                        select_n,
   input wire logic                        read_write_n,
   input wire logic [pcbp_pkg::BUS_W-1:0]  mst_data,
   input wire logic                        mst_data_oe_n,
   input wire logic [pcbp_pkg::BUS_W-1:0]  dev_data,
   input wire logic                        dev_data_oe_n
);
   import pcbp_pkg::*;

   logic [2:0]  rises_r;
   logic        config_clock_q_r;
   logic        link_ok;

   // Device link flops stay unknown until a few link edges after reset
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rises_r <= 3'h0;
      end else if (config_clock && !config_clock_q_r && rises_r != 3'h7) begin
         rises_r <= rises_r + 3'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      config_clock_q_r <= config_clock;
   end

   assign link_ok = (rises_r == 3'h7);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn || !link_ok);

   // ********************
   // Assertions
   // ********************
   a_bus_no_clash: assert property (!dev_data_oe_n |-> mst_data_oe_n)
      else $error("both ends drive the byte bus");
   a_dev_drive_cause: assert property ($fell(dev_data_oe_n) |-> $rose(config_clock) && !select_n && read_write_n)
      else $error("device drives without a selected read edge");
   a_mst_drive_write: assert property (!mst_data_oe_n |-> !select_n && !read_write_n)
      else $error("master drives outside a selected write");
   a_config_clock_half: assert property ($rose(config_clock) |-> config_clock[*4] ##1 !config_clock)
      else $error("link clock high phase is not four cycles");
   a_ctrl_stable: assert property ($rose(config_clock) |-> $stable(select_n) && $stable(read_write_n) && $stable(mst_data))
      else $error("port inputs move at the link edge");
   a_rdata_hold: assert property ($fell(dev_data_oe_n) |=> $stable(dev_data)[*7])
      else $error("readback byte changes within its link period");
   a_dev_release: assert property ($fell(dev_data_oe_n) |-> ##[1:9] $rose(dev_data_oe_n))
      else $error("device keeps the bus too long");
   a_sel_to_edge: assert property ($fell(select_n) |-> ##4 $rose(config_clock))
      else $error("no link edge four cycles after select");

   c_write: cover property ($rose(config_clock) && !select_n && !read_write_n);
   c_readback: cover property ($fell(dev_data_oe_n));
   c_back_to_back: cover property (!select_n[*8] ##1 !select_n);
   c_read_unanswered: cover property ($rose(config_clock) && !select_n && read_write_n && dev_data_oe_n);

endmodule : pcbp_checker

// File: pcbp_device.sv
`timescale 1ns/1ps
// **********************************************************************
// What this block does
// - Byte bus, transfers on rising link clock
// - Lines 0-3 upper nibble, 4-7 lower
// - Line 0 is MSB, line 7 LSB
// - Select low, write low: capture byte
// - Select low, read high: drive byte per edge
// - Select sampled low makes inputs valid
// - Select high: ignore every port input
// - Master holds write low until configuration done
// - Write released during load aborts configuration
// - Select and write order carries no meaning
// - Readback only with keep-port option set
// - Port after completion only with keep-port
// **********************************************************************
module pcbp_device (
   pcbp_if.dev                         link,
   input  wire logic                   clk_sys,
   input  wire logic                   resetn,
   input  wire logic                   keep_port,
   output logic [pcbp_pkg::BUS_W-1:0]  cfg_byte,
   output logic                        cfg_byte_valid,
   output logic                        configured,
   output logic                        aborted,
   output logic                        port_in_user_mode
);
   import pcbp_pkg::*;

   // **********************************************************************
   // Link domain: reset and option synchronisers
   // **********************************************************************
   logic [SYNC_N-1:0]     lrst_s_r;
   logic                  link_rst_n_r;
   logic [SYNC_N-1:0]     keep_s_r;
   logic                  keep_l_r;
   logic [RST_W-1:0]      rst_cnt_r;
   logic                  lreq_r;

   // Link clock stands still in reset, so the link side gets its own reset after release
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rst_cnt_r <= '0;
         lreq_r    <= 1'b0;
      end else if (rst_cnt_r != RST_LAST) begin
         rst_cnt_r <= rst_cnt_r + RST_ONE;
      end else begin
         lreq_r <= 1'b1;
      end
   end

   // Reset path itself carries no reset
   always_ff @(posedge link.config_clock) begin
      lrst_s_r <= {lrst_s_r[SYNC_N-2:0], lreq_r};
      if (lrst_s_r[SYNC_N-1] == lrst_s_r[SYNC_N-2]) begin
         link_rst_n_r <= lrst_s_r[SYNC_N-1];
      end
   end

   always_ff @(posedge link.config_clock) begin
      if (!link_rst_n_r) begin
         keep_s_r <= '0;
         keep_l_r <= 1'b0;
      end else begin
         keep_s_r <= {keep_s_r[SYNC_N-2:0], keep_port};
         if (keep_s_r[SYNC_N-1] == keep_s_r[SYNC_N-2]) begin
            keep_l_r <= keep_s_r[SYNC_N-1];
         end
      end
   end

   // **********************************************************************
   // Link domain: decode of the port pins
   // **********************************************************************
   pcbp_dev_state_t       state_r;
   pcbp_dev_state_t       state_nxt;
   logic                  sel;
   logic                  wr_hit;
   logic                  rd_hit;
   logic                  wr_ok;
   logic                  rd_ok;
   logic [BUS_W-1:0]      bus_byte;
   logic [IDX_W-1:0]      wr_idx_r;

   // Pins sampled at the rising edge that is the transfer edge itself
   assign sel      = !link.select_n;
   assign wr_hit   = sel && !link.read_write_n;
   assign rd_hit   = sel && link.read_write_n;
   assign bus_byte = pcbp_swap_bits(link.config_byte_bus);
   // Once loaded, the port lives on only with the option
   assign wr_ok    = wr_hit && ((state_r != DS_DONE) || keep_l_r);
   assign rd_ok    = rd_hit && (state_r == DS_DONE) && keep_l_r;

   // **********************************************************************
   // Link domain: configuration state
   // **********************************************************************
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         DS_IDLE, DS_ABORT, DS_DONE: begin
            if (wr_ok) begin
               state_nxt = DS_LOAD;
            end
         end
         DS_LOAD: begin
            if (rd_hit) begin
               state_nxt = DS_ABORT;
            end else if (wr_hit && (wr_idx_r == IDX_LAST)) begin
               state_nxt = DS_DONE;
            end
         end
      endcase
   end

   always_ff @(posedge link.config_clock) begin
      if (!link_rst_n_r) begin
         state_r <= DS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // **********************************************************************
   // Link domain: byte store and write index
   // **********************************************************************
   logic [BUS_W-1:0]      mem_r [CFG_LEN];
   logic [IDX_W-1:0]      wr_at;

   // A write outside a load starts a fresh image at index 0
   assign wr_at = (state_r == DS_LOAD) ? wr_idx_r : IDX_ZERO;

   always_ff @(posedge link.config_clock) begin
      if (!link_rst_n_r) begin
         wr_idx_r <= IDX_ZERO;
      end else if (wr_ok) begin
         wr_idx_r <= wr_at + IDX_ONE;
      end
   end

   generate
      for (genvar g = 0; g < CFG_LEN; g++) begin : g_store
         always_ff @(posedge link.config_clock) begin
            if (!link_rst_n_r) begin
               mem_r[g] <= '0;
            end else if (wr_ok && (wr_at == IDX_W'(g))) begin
               mem_r[g] <= bus_byte;
            end
         end
      end
   endgenerate

   // **********************************************************************
   // Link domain: readback driver
   // **********************************************************************
   logic [IDX_W-1:0]      rd_idx_r;
   logic [BUS_W-1:0]      dout_r;
   logic                  doe_n_r;

   // Burst restarts at the first byte whenever the master deselects
   always_ff @(posedge link.config_clock) begin
      if (!link_rst_n_r) begin
         rd_idx_r <= IDX_ZERO;
         dout_r   <= '0;
         doe_n_r  <= 1'b1;
      end else begin
         rd_idx_r <= rd_ok ? (rd_idx_r + IDX_ONE) : IDX_ZERO;
         doe_n_r  <= !rd_ok;
         if (rd_ok) begin
            dout_r <= pcbp_swap_bits(mem_r[rd_idx_r]);
         end
      end
   end

   assign link.dev_data      = dout_r;
   assign link.dev_data_oe_n = doe_n_r;

   // **********************************************************************
   // Link domain: byte event toward the system side
   // **********************************************************************
   logic [BUS_W-1:0]      hold_r;
   logic                  evt_tog_r;
   logic [2:0]            link_flags;

   // Held stable until the next write, which lies a link period away
   always_ff @(posedge link.config_clock) begin
      if (!link_rst_n_r) begin
         hold_r    <= '0;
         evt_tog_r <= 1'b0;
      end else if (wr_ok) begin
         hold_r    <= bus_byte;
         evt_tog_r <= !evt_tog_r;
      end
   end

   assign link_flags = {state_r == DS_ABORT, state_r == DS_DONE, evt_tog_r};

   // **********************************************************************
   // System domain: flag synchronisers
   // **********************************************************************
   logic [2:0]            s1_r;
   logic [2:0]            s2_r;
   logic [2:0]            s3_r;
   logic [2:0]            flt_r;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= link_flags;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   generate
      for (genvar b = 0; b < 3; b++) begin : g_flt
         always_ff @(posedge clk_sys) begin
            if (!resetn) begin
               flt_r[b] <= 1'b0;
            end else if (s2_r[b] == s3_r[b]) begin
               flt_r[b] <= s3_r[b];
            end
         end
      end
   endgenerate

   // **********************************************************************
   // System domain: user outputs
   // **********************************************************************
   logic [BUS_W-1:0]      byte_r;
   logic                  byte_vld_r;
   logic                  tog_seen_r;
   logic                  cfgd_r;
   logic                  abrt_r;
   logic                  user_r;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         tog_seen_r <= 1'b0;
         byte_vld_r <= 1'b0;
         byte_r     <= '0;
      end else begin
         tog_seen_r <= flt_r[0];
         byte_vld_r <= flt_r[0] != tog_seen_r;
         if (flt_r[0] != tog_seen_r) begin
            byte_r <= hold_r;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cfgd_r <= 1'b0;
         abrt_r <= 1'b0;
         user_r <= 1'b0;
      end else begin
         cfgd_r <= flt_r[1];
         abrt_r <= flt_r[2];
         user_r <= flt_r[1] && !keep_port;
      end
   end

   assign cfg_byte          = byte_r;
   assign cfg_byte_valid    = byte_vld_r;
   assign configured        = cfgd_r;
   assign aborted           = abrt_r;
   assign port_in_user_mode = user_r;

endmodule : pcbp_device

// File: pcbp_if.sv
`timescale 1ns/1ps
// **********************************************************************
// Link between configuration master and device
// **********************************************************************
interface pcbp_if;
   import pcbp_pkg::*;

   logic              config_clock;
   logic              select_n;
   logic              read_write_n;
   logic [BUS_W-1:0]  mst_data;
   logic              mst_data_oe_n;
   logic [BUS_W-1:0]  dev_data;
   logic              dev_data_oe_n;
   logic [BUS_W-1:0]  config_byte_bus;

   // Wire level of the shared bus; pulled high when nobody drives
   assign config_byte_bus = !dev_data_oe_n ? dev_data :
                            (!mst_data_oe_n ? mst_data : BUS_PULL);

   modport dev (
      input  config_clock,
      input  select_n,
      input  read_write_n,
      input  config_byte_bus,
      output dev_data,
      output dev_data_oe_n
   );

   modport mst (
      output config_clock,
      output select_n,
      output read_write_n,
      output mst_data,
      output mst_data_oe_n,
      input  config_byte_bus
   );
endinterface : pcbp_if

// File: pcbp_master.sv
`timescale 1ns/1ps
module pcbp_master (
   pcbp_if.mst                         link,
   input  wire logic                   clk_sys,
   input  wire logic                   resetn,
   input  wire logic                   cmd_valid,
   input  wire logic                   cmd_read,
   input  wire logic [pcbp_pkg::BUS_W-1:0] cmd_byte,
   output logic                        cmd_ack,
   output logic [pcbp_pkg::BUS_W-1:0]  rd_byte,
   output logic                        rd_valid,
   output logic                        busy
);
   import pcbp_pkg::*;

   // **********************************************************************
   // Link clock divider
   // **********************************************************************
   logic [CNT_W-1:0]      div_r;
   logic                  config_clock_r;
   logic                  fall_now;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         div_r  <= CNT_ZERO;
         config_clock_r <= 1'b0;
      end else if (div_r == CNT_LAST) begin
         div_r  <= CNT_ZERO;
         config_clock_r <= !config_clock_r;
      end else begin
         div_r <= div_r + 3'h1;
      end
   end

   // Pins change only as the clock falls, half a period before the device samples
   assign fall_now = (div_r == CNT_LAST) && config_clock_r;

   // **********************************************************************
   // Transfer sequencer
   // **********************************************************************
   pcbp_mst_state_t       st_r;
   logic                  sel_n_r;
   logic                  rw_n_r;
   logic [BUS_W-1:0]      dout_r;
   logic                  doe_n_r;
   logic                  ack_r;
   logic [BUS_W-1:0]      rbyte_r;
   logic                  rvld_r;
   logic                  take;

   assign take = fall_now && cmd_valid && ((st_r == MS_IDLE) || ((st_r == MS_XFER) && !rw_n_r));

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_r    <= MS_IDLE;
         sel_n_r <= 1'b1;
         rw_n_r  <= 1'b1;
         dout_r  <= '0;
         doe_n_r <= 1'b1;
      end else if (take) begin
         // Back to back writes keep select low; the write level persists
         st_r    <= MS_XFER;
         sel_n_r <= 1'b0;
         rw_n_r  <= cmd_read;
         dout_r  <= pcbp_swap_bits(cmd_byte);
         doe_n_r <= cmd_read;
      end else if (fall_now) begin
         unique case (st_r)
            MS_XFER: begin
               // A read leaves one extra idle period so the device lets go first
               st_r    <= rw_n_r ? MS_TURN : MS_IDLE;
               sel_n_r <= 1'b1;
               doe_n_r <= 1'b1;
            end
            MS_TURN: begin
               st_r <= MS_IDLE;
            end
            MS_IDLE: begin
               sel_n_r <= 1'b1;
            end
            default: begin
               st_r <= MS_IDLE;
            end
         endcase
      end
   end

   // Device launched its byte at the rise we made half a period ago
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ack_r   <= 1'b0;
         rvld_r  <= 1'b0;
         rbyte_r <= '0;
      end else begin
         ack_r  <= take;
         rvld_r <= fall_now && (st_r == MS_XFER) && rw_n_r;
         if (fall_now && (st_r == MS_XFER) && rw_n_r) begin
            rbyte_r <= pcbp_swap_bits(link.config_byte_bus);
         end
      end
   end

   assign link.config_clock  = config_clock_r;
   assign link.select_n      = sel_n_r;
   assign link.read_write_n  = rw_n_r;
   assign link.mst_data      = dout_r;
   assign link.mst_data_oe_n = doe_n_r;
   assign cmd_ack            = ack_r;
   assign rd_byte            = rbyte_r;
   assign rd_valid           = rvld_r;
   assign busy               = !sel_n_r;

endmodule : pcbp_master

// File: pcbp_pkg.sv
// **********************************************************************
// Shared constants and types of the parallel configuration byte port
// **********************************************************************
package pcbp_pkg;

   // **********************************************************************
   // Widths and sizes
   // **********************************************************************
   localparam int                 BUS_W    = 8;
   localparam int                 CFG_LEN  = 16;
   localparam int                 IDX_W    = 4;
   localparam logic [IDX_W-1:0]   IDX_LAST = 4'hf;
   localparam logic [IDX_W-1:0]   IDX_ONE  = 4'h1;
   localparam logic [IDX_W-1:0]   IDX_ZERO = 4'h0;
   localparam int                 SYNC_N   = 3;
   localparam logic [BUS_W-1:0]   BUS_PULL = 8'hff;

   // **********************************************************************
   // Timing: link clock made by the master from clk_sys
   // **********************************************************************
   localparam int                 SYS_PERIOD_PS  = 25000;
   localparam int                 CONFIG_CLOCK_PERIOD_NS = 200;
   localparam int                 CONFIG_CLOCK_HALF_CYC  = (CONFIG_CLOCK_PERIOD_NS * 1000) / (2 * SYS_PERIOD_PS);
   localparam int                 CNT_W          = 3;
   localparam logic [CNT_W-1:0]   CNT_ZERO       = 3'h0;
   localparam logic [CNT_W-1:0]   CNT_LAST       = CNT_W'(CONFIG_CLOCK_HALF_CYC - 1);
   localparam int                 RST_W          = 5;
   localparam logic [RST_W-1:0]   RST_LAST       = 5'h1f;
   localparam logic [RST_W-1:0]   RST_ONE        = 5'h01;

   // **********************************************************************
   // State machines
   // **********************************************************************
   typedef enum logic [1:0] {
      DS_IDLE  = 2'h0,
      DS_LOAD  = 2'h1,
      DS_DONE  = 2'h3,
      DS_ABORT = 2'h2
   } pcbp_dev_state_t;

   typedef enum logic [1:0] {
      MS_IDLE = 2'h0,
      MS_XFER = 2'h1,
      MS_TURN = 2'h3
   } pcbp_mst_state_t;

   // Bus line 0 carries the byte's MSB, so the map is a bit reversal both ways
   function automatic logic [BUS_W-1:0] pcbp_swap_bits(input logic [BUS_W-1:0] v);
      logic [BUS_W-1:0] r;
      r = '0;
      for (int i = 0; i < BUS_W; i++) begin
         r[BUS_W-1-i] = v[i];
      end
      return r;
   endfunction : pcbp_swap_bits

endpackage : pcbp_pkg
